// ---- rtl/ccl_pkg.sv ----
// Purpose: shared constants and types for the channel correction bank
// Assumes: byte-wide register port, 20-bit signed conversion codes
// Notes:   offsets are byte addresses of the configuration space
package ccl_pkg;
	localparam int          CODE_W       = 20;             // conversion code width
	localparam logic [7:0]  MAP_BASE     = 8'h2b;          // first mapped byte
	localparam logic [7:0]  MAP_LAST     = 8'h3d;          // last mapped byte
	localparam logic [7:0]  OFF_ADDR     = 8'h2b;          // offset, 3 bytes
	localparam logic [7:0]  GAIN_ADDR    = 8'h2e;          // gain, 2 bytes
	localparam logic [7:0]  PHASE_ADDR   = 8'h30;          // phase, 2 bytes
	localparam logic [7:0]  OVR_ADDR     = 8'h32;          // over limit, 3 bytes
	localparam logic [7:0]  UND_ADDR     = 8'h35;          // under limit, 3 bytes
	localparam logic [7:0]  PAT_ADDR     = 8'h38;          // fixed pattern, 4 bytes
	localparam logic [7:0]  OVR_ST_ADDR  = 8'h3c;          // over limit status
	localparam logic [7:0]  UND_ST_ADDR  = 8'h3d;          // under limit status
	localparam logic [23:0] OFF_RST      = 24'h000000;     // zero offset
	localparam logic [15:0] GAIN_RST     = 16'h8000;       // unity gain
	localparam logic [15:0] PHASE_RST    = 16'h0000;       // no phase term
	localparam logic [23:0] OVR_RST      = 24'h7ffff0;     // most positive code
	localparam logic [23:0] UND_RST      = 24'h800000;     // most negative code
	localparam logic [27:0] PAT_LOW_RST  = 28'hace3c2a;    // pattern below channel nibble
	localparam int          GAIN_SHIFT   = 15;             // gain binary point
	localparam int          FLD_LSB      = 4;              // code field starts here
	localparam int          FIFO_DEPTH   = 16;             // output buffer words
	localparam int          PKT_W        = 32;             // output packet width
	localparam logic [7:0]  PKT_PAD      = 8'h00;          // unused packet bits

	// software-visible correction settings
	typedef struct packed {
		logic signed [CODE_W-1:0] offset;
		logic [15:0]              gain;
		logic [15:0]              phase;
		logic signed [CODE_W-1:0] over_thr;
		logic signed [CODE_W-1:0] under_thr;
	} ccl_cfg_s;
endpackage

// ---- rtl/ccl_fifo.sv ----
// Purpose: small synchronous fifo for output packets
// Assumes: one clock, synchronous active-low reset
// Notes:   depth must be a power of two
module ccl_fifo
	import ccl_pkg::*;
#(
	parameter int W = PKT_W,
	parameter int D = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	// fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_ff [D];     // packet storage
	logic [AW-1:0] wr_ff;         // write pointer
	logic [AW-1:0] rd_ff;         // read pointer
	logic [AW:0]   cnt_ff;        // words held
	wire           push = in_valid_i && in_ready_o;
	wire           pop  = out_valid_o && out_ready_i;

	assign in_ready_o  = (cnt_ff != (AW+1)'(D));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem_ff[rd_ff];

	// storage has no reset; only pointers and fill count carry state
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data_i;
		end
	end

	// pointer and fill count
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff  <= push ? wr_ff + 1'b1 : wr_ff;
			rd_ff  <= pop ? rd_ff + 1'b1 : rd_ff;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	fifo_bound_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		cnt_ff <= (AW+1)'(D)) else $error("fifo count beyond depth");
endmodule

// ---- rtl/ccl_chan.sv ----
// Purpose: per-channel offset, gain, phase, limit and test pattern logic
// Assumes: samples arrive one per valid, synchronous to clk_i
// Notes:   corrected codes saturate to 20 bits before averaging
//
// Behaviour
// - add signed 20-bit offset to every result
// - offset register resets to zero
// - multiply every result by unsigned gain
// - gain resets to unity, 0x8000
// - phase term used only when oversampling
// - result above over limit sets flag
// - result below under limit sets flag
// - test mode sends fixed pattern packets
// - pattern reset carries channel number nibble
// - oversampling averages two to ratio+1 results
module ccl_chan
	import ccl_pkg::*;
#(
	parameter logic [3:0] CHAN = 4'h0   // channel number
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	// register port
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [7:0]        reg_addr_i,
	input  wire logic [7:0]        reg_wdata_i,
	output logic [7:0]             reg_rdata_o,
	output logic                   reg_rvalid_o,
	// mode inputs
	input  wire logic              os_en_i,
	input  wire logic [3:0]        average_count_select_i,
	input  wire logic              test_pat_en_i,
	// conversion results in
	input  wire logic              sample_valid_i,
	output logic                   sample_ready_o,
	input  wire logic [CODE_W-1:0] sample_i,
	// packets out
	output logic                   out_valid_o,
	input  wire logic              out_ready_i,
	output logic [PKT_W-1:0]       out_data_o,
	// flags
	output logic                   over_flag_o,
	output logic                   under_flag_o
);
	// register images, byte-addressable
	logic [23:0] off_ff;          // chan_zero_offset_corr
	logic [15:0] gain_ff;         // chan_zero_gain_corr
	logic [15:0] phase_ff;        // chan_zero_phase_corr
	logic [23:0] ovr_ff;          // chan_zero_over_limit
	logic [23:0] und_ff;          // chan_zero_under_limit
	logic [31:0] pat_ff;          // per_chan_fixed_pattern
	logic        ovr_flag_ff;     // chan_zero_over_limit_flag
	logic        und_flag_ff;     // chan_zero_under_limit_flag
	logic [7:0]  rdata_ff;        // read answer
	logic        rvalid_ff;       // read answer strobe
	// averaging state
	logic signed [CODE_W+16:0] acc_ff;   // running sum
	logic [16:0]               cnt_ff;   // samples in window
	logic [15:0]               skip_ff;  // phase samples still to drop
	ccl_cfg_s                  cfg;      // decoded settings

	assign cfg.offset    = off_ff[23:FLD_LSB];
	assign cfg.gain      = gain_ff;
	assign cfg.phase     = phase_ff;
	assign cfg.over_thr  = ovr_ff[23:FLD_LSB];
	assign cfg.under_thr = und_ff[23:FLD_LSB];

	// address decode
	wire       in_map  = (reg_addr_i >= MAP_BASE) && (reg_addr_i <= MAP_LAST);
	wire [7:0] rel     = reg_addr_i - MAP_BASE;
	wire [7:0] o_off   = reg_addr_i - OFF_ADDR;
	wire [7:0] o_gain  = reg_addr_i - GAIN_ADDR;
	wire [7:0] o_phase = reg_addr_i - PHASE_ADDR;
	wire [7:0] o_ovr   = reg_addr_i - OVR_ADDR;
	wire [7:0] o_und   = reg_addr_i - UND_ADDR;
	wire [7:0] o_pat   = reg_addr_i - PAT_ADDR;
	wire       w_off   = reg_wr_i && (o_off < 8'h03);
	wire       w_gain  = reg_wr_i && (o_gain < 8'h02);
	wire       w_phase = reg_wr_i && (o_phase < 8'h02);
	wire       w_ovr   = reg_wr_i && (o_ovr < 8'h03);
	wire       w_und   = reg_wr_i && (o_und < 8'h03);
	wire       w_pat   = reg_wr_i && (o_pat < 8'h04);
	wire       clr_ovr = reg_wr_i && (reg_addr_i == OVR_ST_ADDR) && reg_wdata_i[0];
	wire       clr_und = reg_wr_i && (reg_addr_i == UND_ST_ADDR) && reg_wdata_i[0];
	// reserved low nibble of the field registers always stores zero
	wire [7:0] wd_fld  = {reg_wdata_i[7:4], 4'h0};

	// readback map, low byte at lowest address
	wire [151:0] rd_map = {7'h00, und_flag_ff, 7'h00, ovr_flag_ff, pat_ff,
		und_ff, ovr_ff, phase_ff, gain_ff, off_ff};
	wire [7:0] rd_byte = in_map ? rd_map[rel*8 +: 8] : 8'h00;

	// correction datapath
	wire signed [CODE_W-1:0] code = sample_i;
	wire signed [CODE_W+16:0] prod = code * $signed({1'b0, cfg.gain});
	wire signed [CODE_W+16:0] scaled = prod >>> GAIN_SHIFT;
	wire signed [CODE_W+16:0] summed = scaled + (CODE_W+17)'(cfg.offset);
	localparam logic signed [CODE_W+16:0] MAXC = (CODE_W+17)'(20'sh7ffff);
	// most negative code, sign-extended; a leading minus here would flip it positive
	localparam logic signed [CODE_W+16:0] MINC = (CODE_W+17)'(20'sh80000);
	// saturation keeps a large gain from wrapping the sign
	wire signed [CODE_W-1:0] corr = (summed > MAXC) ? 20'sh7ffff :
		(summed < MINC) ? 20'sh80000 : summed[CODE_W-1:0];
	wire is_over  = corr > cfg.over_thr;
	wire is_under = corr < cfg.under_thr;

	// averaging window control
	wire        take    = sample_valid_i && sample_ready_o;
	wire [4:0]  sh      = 5'(average_count_select_i) + 5'h01;
	wire [16:0] target  = 17'h00001 << sh;
	wire        skipping = os_en_i && (skip_ff != 16'h0000);
	wire        add_it  = take && os_en_i && !skipping;
	wire        win_end = add_it && (cnt_ff + 17'h00001 == target);
	wire signed [CODE_W+16:0] acc_nx = acc_ff + (CODE_W+17)'(corr);
	wire signed [CODE_W+16:0] avg_w  = acc_nx >>> sh;
	wire [CODE_W-1:0] res = os_en_i ? avg_w[CODE_W-1:0] : corr;
	wire push = os_en_i ? win_end : take;
	wire [PKT_W-1:0] pkt = test_pat_en_i ? pat_ff : {CHAN, PKT_PAD, res};

	// register writes
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			off_ff   <= OFF_RST;
			gain_ff  <= GAIN_RST;
			phase_ff <= PHASE_RST;
			ovr_ff   <= OVR_RST;
			und_ff   <= UND_RST;
			pat_ff   <= {CHAN, PAT_LOW_RST};
		end else begin
			if (w_off) off_ff[o_off*8 +: 8] <= (o_off == 8'h00) ? wd_fld : reg_wdata_i;
			if (w_gain) gain_ff[o_gain*8 +: 8] <= reg_wdata_i;
			if (w_phase) phase_ff[o_phase*8 +: 8] <= reg_wdata_i;
			if (w_ovr) ovr_ff[o_ovr*8 +: 8] <= (o_ovr == 8'h00) ? wd_fld : reg_wdata_i;
			if (w_und) und_ff[o_und*8 +: 8] <= (o_und == 8'h00) ? wd_fld : reg_wdata_i;
			if (w_pat) pat_ff[o_pat*8 +: 8] <= reg_wdata_i;
		end
	end

	// sticky limit flags; a new event beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ovr_flag_ff <= 1'b0;
			und_flag_ff <= 1'b0;
		end else begin
			ovr_flag_ff <= (take && is_over) || (ovr_flag_ff && !clr_ovr);
			und_flag_ff <= (take && is_under) || (und_flag_ff && !clr_und);
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= reg_rd_i ? rd_byte : rdata_ff;
			rvalid_ff <= reg_rd_i;
		end
	end

	// averaging accumulator; phase delays the first window
	always_ff @(posedge clk_i) begin
		if (!resetn_i || !os_en_i) begin
			acc_ff  <= '0;
			cnt_ff  <= '0;
			skip_ff <= resetn_i ? cfg.phase : PHASE_RST;
		end else if (take && skipping) begin
			skip_ff <= skip_ff - 16'h0001;
		end else if (win_end) begin
			acc_ff <= '0;
			cnt_ff <= '0;
		end else if (add_it) begin
			acc_ff <= acc_nx;
			cnt_ff <= cnt_ff + 17'h00001;
		end
	end

	ccl_fifo #(
		.W (PKT_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (push),
		.in_ready_o  (sample_ready_o),
		.in_data_i   (pkt),
		.out_valid_o (out_valid_o),
		.out_ready_i (out_ready_i),
		.out_data_o  (out_data_o)
	);

	assign reg_rdata_o  = rdata_ff;
	assign reg_rvalid_o = rvalid_ff;
	assign over_flag_o  = ovr_flag_ff;
	assign under_flag_o = und_flag_ff;

	off_zero_a: assert property (@(posedge clk_i) $rose(resetn_i) |-> off_ff == OFF_RST)
		else $error("offset not zero after reset");
	gain_unity_a: assert property (@(posedge clk_i) $rose(resetn_i) |-> gain_ff == GAIN_RST)
		else $error("gain not unity after reset");
	pat_chan_a: assert property (@(posedge clk_i) $rose(resetn_i) |-> pat_ff[31:28] == CHAN)
		else $error("pattern nibble not channel");
	over_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		take && is_over |=> ovr_flag_ff) else $error("over flag missed");
	under_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		take && is_under |=> und_flag_ff) else $error("under flag missed");
	flag_hold_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ovr_flag_ff && !clr_ovr |=> ovr_flag_ff) else $error("over flag dropped");
	off_add_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		gain_ff == GAIN_RST && off_ff == OFF_RST |-> corr == code) else $error("unity path altered");
	pat_out_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		push && test_pat_en_i && sample_ready_o |=> out_valid_o) else $error("pattern not queued");
	phase_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!os_en_i && take |=> out_valid_o) else $error("phase gated normal mode");
	win_len_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		os_en_i |-> cnt_ff < target) else $error("window length wrong");
endmodule

// ---- tb/ccl_host_model.sv ----
// Purpose: host side drain model for the corrected packet stream
// Assumes: a packet is popped on valid and ready at a rising edge
// Notes:   ready is registered, so a stall request shows one edge later
module ccl_host_model
	import ccl_pkg::*;
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	// stall request from the bench
	input  wire logic             stall_i,
	// packet stream from the channel
	input  wire logic             out_valid_i,
	output logic                  out_ready_o,
	input  wire logic [PKT_W-1:0] out_data_i,
	// last popped packet, shown for one cycle
	output logic                  got_o,
	output logic [PKT_W-1:0]      got_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ready follows the stall request; a pop is seen on valid and ready
	always_ff @(posedge clk_i) begin
		out_ready_o <= resetn_i & ~stall_i;
		got_o       <= resetn_i & out_valid_i & out_ready_o;
		got_data_o  <= out_data_i;
	end
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench for one correction channel
// Assumes: byte register port, host model drains the packets
// Notes:   channel number 3 so the pattern nibble is visible
module tb
	import ccl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] CH = 4'h3;  // non-zero channel number
	// design inputs, all given a value at time zero
	logic        clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic        os_en_i = 0, test_pat_en_i = 0, sample_valid_i = 0, stall = 0;
	logic [7:0]  reg_addr_i = 0, reg_wdata_i = 0;
	logic [3:0]  average_count_select_i = 0;
	logic [19:0] sample_i = 0;
	// design outputs and model outputs
	logic [7:0]  reg_rdata_o;
	logic        reg_rvalid_o, sample_ready_o, out_valid_o, out_ready_i, over_flag_o, under_flag_o, got_o;
	logic [31:0] out_data_o, got_data_o;
	int          n_fail = 0, num_checks = 0, cyc = 0;
	// expected bytes of 0x2b..0x3d after reset
	logic [7:0]  rst_b [19] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'hf0, 8'hff, 8'h7f,
		8'h00, 8'h00, 8'h80, 8'h2a, 8'h3c, 8'hce, {CH, 4'ha}, 8'h00, 8'h00};
	ccl_chan #(.CHAN(CH)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .os_en_i(os_en_i), .average_count_select_i(average_count_select_i),
		.test_pat_en_i(test_pat_en_i), .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
		.sample_i(sample_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o),
		.over_flag_o(over_flag_o), .under_flag_o(under_flag_o));
	ccl_host_model host_u (.clk_i(clk_i), .resetn_i(resetn_i), .stall_i(stall), .out_valid_i(out_valid_o),
		.out_ready_o(out_ready_i), .out_data_i(out_data_o), .got_o(got_o), .got_data_o(got_data_o));
	// 50 MHz clock
	always #10 clk_i = ~clk_i;
	// hang guard: the tests need a few hundred cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one byte write, strobe held for exactly one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// one byte read; the answer strobe stands only in the next cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk({31'h0, reg_rvalid_o}, 32'h1);
		chk({24'h0, reg_rdata_o}, {24'h0, exp});
	endtask
	// offer one sample and hold it until an edge sees ready high
	task automatic send(input logic [19:0] s);
		int   n;
		logic rdy;
		n = 0;
		@(posedge clk_i);
		sample_valid_i <= 1'b1;
		sample_i       <= s;
		do begin
			#1;
			rdy = sample_ready_o;
			@(posedge clk_i);
			n++;
		end while (rdy !== 1'b1 && n < 100);
		sample_valid_i <= 1'b0;
	endtask
	// wait for the next popped packet and compare it
	task automatic pkt(input logic [31:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (got_o !== 1'b1 && n < 100);
		chk({31'h0, got_o}, 32'h1);
		chk(got_data_o, exp);
	endtask
	task automatic xfer(input logic [19:0] s, input logic [19:0] r);
		send(s);
		pkt({CH, 8'h00, r});
	endtask
	task automatic report_and_stop;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 19; i++) rd(8'(8'h2b + i), rst_b[i]);
		// unmapped bytes read zero and ignore writes
		wr(8'h3e, 8'hff);
		rd(8'h3e, 8'h00);
		rd(8'h2a, 8'h00);
		// phase set but ignored while not oversampling
		wr(8'h30, 8'h01);
		xfer(20'h00010, 20'h00010);
		wr(8'h2b, 8'hff);
		rd(8'h2b, 8'hf0);
		wr(8'h2b, 8'h00);
		// over limit 0x00100, under limit -256
		wr(8'h32, 8'h00);
		wr(8'h33, 8'h10);
		wr(8'h34, 8'h00);
		wr(8'h36, 8'hf0);
		wr(8'h37, 8'hff);
		xfer(20'h00100, 20'h00100);
		chk(over_flag_o, 1'b0);
		xfer(20'h00101, 20'h00101);
		chk(over_flag_o, 1'b1);
		xfer(20'h00000, 20'h00000);
		rd(8'h3c, 8'h01);
		wr(8'h3c, 8'h01);
		rd(8'h3c, 8'h00);
		chk(over_flag_o, 1'b0);
		xfer(20'hfff00, 20'hfff00);
		chk(under_flag_o, 1'b0);
		xfer(20'hffeff, 20'hffeff);
		chk(under_flag_o, 1'b1);
		wr(8'h3d, 8'h01);
		rd(8'h3d, 8'h00);
		// offset +5 and gain one half, both signs
		wr(8'h2b, 8'h50);
		wr(8'h2f, 8'h40);
		xfer(20'h00100, 20'h00085);
		xfer(20'hfff00, 20'hfff85);
		@(posedge clk_i);
		test_pat_en_i <= 1'b1;
		send(20'h00001);
		pkt({CH, 28'hace3c2a});
		wr(8'h38, 8'h55);
		send(20'h00001);
		pkt({CH, 28'hace3c55});
		@(posedge clk_i);
		test_pat_en_i <= 1'b0;
		// each window: one skipped sample, then 2^(code+1) samples
		for (int c = 0; c < 4; c++) begin
			@(posedge clk_i);
			os_en_i                <= 1'b0;
			average_count_select_i <= 4'(c);
			@(posedge clk_i);
			os_en_i <= 1'b1;
			send(20'h00000);
			repeat (2 << c) send(20'h00020);
			pkt({CH, 8'h00, 20'h00015});
		end
		@(posedge clk_i);
		os_en_i <= 1'b0;
		// fill the buffer with the drain stalled, then empty it
		stall <= 1'b1;
		for (int i = 0; i < 16; i++) send(20'(i));
		#1;
		chk({31'h0, sample_ready_o}, 32'h0);
		stall <= 1'b0;
		for (int i = 0; i < 16; i++) pkt({CH, 8'h00, 20'(i / 2 + 5)});
		chk({31'h0, sample_ready_o}, 32'h1);
		report_and_stop();
	end
endmodule
